// *** rtl/hptc_ctrl.sv ***
// playback trigger, source selection and power-state control
`timescale 1ns/1ps
`include "hptc_regs.svh"
// Notes on behaviour
// - each trigger pin fires on rising, falling or both edges
// - a pin maps to one or two sequences; odd events first, even second
// - three trigger pins start up to six sequences from idle
// - wake on trigger or host play request; drive starts after 0.75 ms
// - host port works in every state; settings kept while powered
// - supply enable low resets all logic and clears settings
// - drive level follows register, input pwm or memory source
// - in register streaming, host writes the drive level directly
// - input pwm is low-pass filtered into the envelope level
// - output bridge switches differentially at 187.5 kHz
// - drive frequency settable from 25 Hz to 1000 Hz with amplitude
// - wave shape square, sine or custom
// - resonance tracking switchable; off means open loop at set frequency
// - overdrive and braking for rotating mass, or resonant with tracking
// - actuator type chosen by configuration
// - any fault ends drive and returns straight to idle
// - after playback ends, return to idle keeping state
module hptc_ctrl
  import hptc_pkg::*;
#(
  parameter int N_TRIG = 3,
  parameter int SEQ_W = 4,
  parameter int LVL_W = 8,
  parameter int WAKE_CYC = `HPTC_WAKE_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_io_supply_enable_pin,
  input wire logic [N_TRIG-1:0] i_trigger_input_pin,
  input wire hptc_edge_t i_edge_sel [N_TRIG],
  input wire logic [N_TRIG-1:0] i_two_seq,
  input wire logic [SEQ_W-1:0] i_seq_first [N_TRIG],
  input wire logic [SEQ_W-1:0] i_seq_second [N_TRIG],
  input wire logic i_host_access,
  input wire logic i_host_play,
  input wire hptc_src_t i_src_sel,
  input wire logic [LVL_W-1:0] i_override_level,
  input wire logic i_pwm_in,
  input wire logic [LVL_W-1:0] i_mem_level,
  input wire logic i_mem_done,
  input wire logic [9:0] i_freq_hz,
  input wire hptc_wave_t i_wave_sel,
  input wire logic i_track_en,
  input wire logic i_accel_en,
  input wire logic i_brake_en,
  input wire logic i_rotating_mass_actuator,
  input wire logic i_fault,
  output logic o_drive_active,
  output logic o_idle,
  output logic [SEQ_W-1:0] o_seq_id,
  output logic o_seq_start,
  output logic [LVL_W-1:0] o_drive_level,
  output logic o_out_p,
  output logic o_out_n,
  output logic [9:0] o_drive_freq_hz,
  output hptc_wave_t o_wave,
  output logic o_closed_loop,
  output logic o_accel_on,
  output logic o_brake_on
);
  typedef enum logic [1:0] {
    HPTC_ST_IDLE,
    HPTC_ST_WAKE,
    HPTC_ST_DRIVE
  } hptc_state_t;

  localparam int PWM_CYC = `HPTC_PWM_CYC;
  localparam int CNT_W = $clog2(WAKE_CYC + 1);
  localparam int PWM_W = $clog2(PWM_CYC + 1);
  localparam int ACC_W = LVL_W + `HPTC_LPF_SHIFT;

  logic en_s1_q, en_s2_q, en_s3_q, en_lvl_q;
  // supply enable low is a full reset of all state
  wire rst_b = i_rst_b && en_lvl_q;

  hptc_trig_if #(.N(N_TRIG)) trig ();

  hptc_trig_detect #(.N(N_TRIG)) u_trig (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(rst_b),
    .i_trigger_input_pin(i_trigger_input_pin),
    .i_edge_sel(i_edge_sel),
    .trig(trig)
  );

  hptc_state_t st_q, st_d;
  logic [CNT_W-1:0] wake_cnt_q;
  logic [SEQ_W-1:0] seq_q, pend_seq_q;
  logic start_q;
  logic act_q, idle_q;
  logic [LVL_W-1:0] lvl_q;
  logic [PWM_W-1:0] pwm_cnt_q;
  logic outp_q, outn_q;
  logic [9:0] freq_q;
  hptc_wave_t wave_q;
  logic cl_q, acc_q, brk_q;
  logic pw_s1_q, pw_s2_q, pw_s3_q, pw_lvl_q;
  logic [ACC_W-1:0] lpf_q;

  // ----------------------------------------
  // sequence selection from trigger events
  // ----------------------------------------
  function automatic logic [SEQ_W-1:0] pick_seq(input logic [N_TRIG-1:0] ev,
                                                input logic [N_TRIG-1:0] odd);
    logic [SEQ_W-1:0] r;
    r = '0;
    for (int i = N_TRIG - 1; i >= 0; i--) begin
      if (ev[i]) begin
        r = (i_two_seq[i] && !odd[i]) ? i_seq_second[i] : i_seq_first[i];
      end
    end
    return r;
  endfunction

  wire any_trig = |trig.event_p;
  wire [SEQ_W-1:0] trig_seq = pick_seq(trig.event_p, trig.odd);
  wire wake_req = any_trig || i_host_play;
  wire wake_done = (wake_cnt_q == CNT_W'(WAKE_CYC - 1));
  wire play_end = (st_q == HPTC_ST_DRIVE) && (i_src_sel == HPTC_SRC_MEM) && i_mem_done;
  wire host_stop = (st_q == HPTC_ST_DRIVE) && (i_src_sel != HPTC_SRC_MEM) && !i_host_play;

  // ----------------------------------------
  // power state machine
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      HPTC_ST_IDLE: begin
        if (wake_req && !i_fault) begin
          st_d = HPTC_ST_WAKE;
        end
      end
      HPTC_ST_WAKE: begin
        if (i_fault) begin
          st_d = HPTC_ST_IDLE;
        end else if (wake_done) begin
          st_d = HPTC_ST_DRIVE;
        end
      end
      HPTC_ST_DRIVE: begin
        if (i_fault) begin
          st_d = HPTC_ST_IDLE;
        end else if (play_end || host_stop) begin
          st_d = HPTC_ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    en_s1_q <= i_io_supply_enable_pin;
    en_s2_q <= en_s1_q;
    en_s3_q <= en_s2_q;
    // level moves only once flops two and three agree
    if (en_s2_q == en_s3_q) begin
      en_lvl_q <= en_s2_q;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!rst_b) begin
      st_q <= HPTC_ST_IDLE;
      wake_cnt_q <= '0;
      pend_seq_q <= '0;
      seq_q <= '0;
      start_q <= 1'b0;
      act_q <= 1'b0;
      idle_q <= 1'b1;
    end else begin
      st_q <= st_d;
      wake_cnt_q <= (st_q == HPTC_ST_WAKE) ? wake_cnt_q + 1'b1 : '0;
      if (st_q == HPTC_ST_IDLE && any_trig) begin
        pend_seq_q <= trig_seq;
      end
      start_q <= (st_q == HPTC_ST_WAKE) && (st_d == HPTC_ST_DRIVE);
      if ((st_q == HPTC_ST_WAKE) && (st_d == HPTC_ST_DRIVE)) begin
        seq_q <= pend_seq_q;
      end
      act_q <= (st_d == HPTC_ST_DRIVE);
      idle_q <= (st_d == HPTC_ST_IDLE);
    end
  end

  // ----------------------------------------
  // input pwm low-pass filter
  // ----------------------------------------
  wire pw_agree = (pw_s2_q == pw_s3_q);
  wire [ACC_W-1:0] pw_in = pw_lvl_q ? {{`HPTC_LPF_SHIFT{1'b0}}, {LVL_W{1'b1}}} : '0;
  wire [ACC_W-1:0] lpf_d = lpf_q - (lpf_q >> `HPTC_LPF_SHIFT) + pw_in;

  always_ff @(posedge i_clk_sys) begin
    if (!rst_b) begin
      pw_s1_q <= 1'b0;
      pw_s2_q <= 1'b0;
      pw_s3_q <= 1'b0;
      pw_lvl_q <= 1'b0;
      lpf_q <= '0;
    end else begin
      pw_s1_q <= i_pwm_in;
      pw_s2_q <= pw_s1_q;
      pw_s3_q <= pw_s2_q;
      if (pw_agree) begin
        pw_lvl_q <= pw_s2_q;
      end
      lpf_q <= lpf_d;
    end
  end

  // ----------------------------------------
  // level source and drive configuration
  // ----------------------------------------
  wire [LVL_W-1:0] pwm_lvl = lpf_q[ACC_W-1 -: LVL_W];
  wire [LVL_W-1:0] src_lvl = (i_src_sel == HPTC_SRC_REG) ? i_override_level :
                             (i_src_sel == HPTC_SRC_PWM) ? pwm_lvl : i_mem_level;
  wire [9:0] f_lo = 10'(`HPTC_FREQ_MIN_HZ);
  wire [9:0] f_hi = 10'(`HPTC_FREQ_MAX_HZ);
  wire [9:0] f_clamp = (i_freq_hz < f_lo) ? f_lo : (i_freq_hz > f_hi) ? f_hi : i_freq_hz;
  wire lra_assist = !i_rotating_mass_actuator && i_track_en;
  wire assist_ok = i_rotating_mass_actuator || lra_assist;
  wire drv = (st_q == HPTC_ST_DRIVE);
  wire pwm_wrap = (pwm_cnt_q == PWM_W'(PWM_CYC - 1));
  wire [LVL_W-1:0] pwm_pos = pwm_cnt_q[PWM_W-1 -: LVL_W];
  wire on_phase = drv && (pwm_pos < lvl_q);

  always_ff @(posedge i_clk_sys) begin
    if (!rst_b) begin
      lvl_q <= `HPTC_LVL_RST;
      pwm_cnt_q <= '0;
      outp_q <= 1'b0;
      outn_q <= 1'b0;
      freq_q <= 10'(`HPTC_FREQ_MIN_HZ);
      wave_q <= HPTC_WAVE_SQUARE;
      cl_q <= 1'b0;
      acc_q <= 1'b0;
      brk_q <= 1'b0;
    end else begin
      lvl_q <= drv ? src_lvl : `HPTC_LVL_RST;
      pwm_cnt_q <= pwm_wrap ? '0 : pwm_cnt_q + 1'b1;
      outp_q <= on_phase;
      outn_q <= drv && !on_phase;
      freq_q <= i_track_en ? freq_q : f_clamp;
      wave_q <= i_wave_sel;
      cl_q <= i_track_en;
      acc_q <= drv && i_accel_en && assist_ok;
      brk_q <= drv && i_brake_en && assist_ok;
    end
  end

  // settings live in the host's registers outside; reset returns the registered copies here to 25 Hz, square wave, open loop
  assign o_drive_active = act_q;
  assign o_idle = idle_q;
  assign o_seq_id = seq_q;
  assign o_seq_start = start_q;
  assign o_drive_level = lvl_q;
  assign o_out_p = outp_q;
  assign o_out_n = outn_q;
  assign o_drive_freq_hz = freq_q;
  assign o_wave = wave_q;
  assign o_closed_loop = cl_q;
  assign o_accel_on = acc_q;
  assign o_brake_on = brk_q;
endmodule

// *** rtl/hptc_regs.svh ***
// timing counts and reset values for the playback trigger control block
`ifndef HPTC_REGS_SVH
`define HPTC_REGS_SVH
`define HPTC_CLK_HZ 200000000
`define HPTC_WAKE_US 750
`define HPTC_WAKE_CYC ((`HPTC_CLK_HZ / 1000000) * `HPTC_WAKE_US)
`define HPTC_PWM_OUT_HZ 187500
`define HPTC_PWM_CYC (`HPTC_CLK_HZ / `HPTC_PWM_OUT_HZ)
`define HPTC_FREQ_MIN_HZ 25
`define HPTC_FREQ_MAX_HZ 1000
`define HPTC_LPF_SHIFT 4
`define HPTC_LVL_RST 8'h00
`endif

// *** rtl/hptc_pkg.sv ***
// types for the playback trigger control block
package hptc_pkg;
  typedef enum logic [1:0] {
    HPTC_EDGE_RISE,
    HPTC_EDGE_FALL,
    HPTC_EDGE_BOTH
  } hptc_edge_t;
  typedef enum logic [1:0] {
    HPTC_SRC_REG,
    HPTC_SRC_PWM,
    HPTC_SRC_MEM
  } hptc_src_t;
  typedef enum logic [1:0] {
    HPTC_WAVE_SQUARE,
    HPTC_WAVE_SINE,
    HPTC_WAVE_CUSTOM
  } hptc_wave_t;
endpackage

// *** rtl/hptc_trig_if.sv ***
// trigger events passed from the pin conditioner to the controller
`timescale 1ns/1ps
interface hptc_trig_if #(parameter int N = 3);
  logic [N-1:0] event_p;
  logic [N-1:0] odd;
  modport src (output event_p, output odd);
  modport dst (input event_p, input odd);
endinterface

// *** rtl/hptc_trig_detect.sv ***
// trigger pin synchroniser, edge detector and odd/even event counter
`timescale 1ns/1ps
module hptc_trig_detect
  import hptc_pkg::*;
#(
  parameter int N = 3
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic [N-1:0] i_trigger_input_pin,
  input wire hptc_edge_t i_edge_sel [N],
  hptc_trig_if.src trig
);
  logic [N-1:0] s1_q, s2_q, s3_q;
  logic [N-1:0] lvl_q;
  logic [N-1:0] odd_q;
  logic [N-1:0] ev_q;

  // ----------------------------------------
  // per-pin conditioning
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_pin
      wire agree = (s2_q[g] == s3_q[g]);
      wire rise = agree && s2_q[g] && !lvl_q[g];
      wire fall = agree && !s2_q[g] && lvl_q[g];
      wire hit = ((i_edge_sel[g] == HPTC_EDGE_RISE) && rise) ||
                 ((i_edge_sel[g] == HPTC_EDGE_FALL) && fall) ||
                 ((i_edge_sel[g] == HPTC_EDGE_BOTH) && (rise || fall));
      always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
          s3_q[g] <= 1'b0;
          lvl_q[g] <= 1'b0;
          ev_q[g] <= 1'b0;
          odd_q[g] <= 1'b0;
        end else begin
          s1_q[g] <= i_trigger_input_pin[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          if (agree) begin
            lvl_q[g] <= s2_q[g];
          end
          ev_q[g] <= hit;
          // odd events toggle to high, even events back to low
          if (hit) begin
            odd_q[g] <= !odd_q[g];
          end
        end
      end
    end
  endgenerate

  assign trig.event_p = ev_q;
  assign trig.odd = odd_q;
endmodule

// *** tb/hptc_ctrl_properties.sv ***
// port assertions for the playback trigger control block
`timescale 1ns/1ps
module hptc_ctrl_properties
  import hptc_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_io_supply_enable_pin,
  input wire logic [9:0] i_freq_hz,
  input wire hptc_wave_t i_wave_sel,
  input wire logic i_track_en,
  input wire logic i_accel_en,
  input wire logic i_brake_en,
  input wire logic i_rotating_mass_actuator,
  input wire logic i_fault,
  input wire logic o_drive_active,
  input wire logic o_idle,
  input wire logic o_seq_start,
  input wire logic o_out_p,
  input wire logic o_out_n,
  input wire logic [9:0] o_drive_freq_hz,
  input wire hptc_wave_t o_wave,
  input wire logic o_closed_loop,
  input wire logic o_accel_on,
  input wire logic o_brake_on
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b || !i_io_supply_enable_pin);
  // ----------------------------------------
  // state, bridge and drive settings
  // ----------------------------------------
  idle_excl_a: assert property (o_drive_active |-> !o_idle)
    else $error("idle and drive together");
  bridge_idle_a: assert property (!o_drive_active [*3] |-> !o_out_p && !o_out_n)
    else $error("bridge switching outside drive");
  bridge_comp_a: assert property (o_drive_active [*3] |-> o_out_p != o_out_n)
    else $error("bridge legs not complementary");
  fault_exit_a: assert property (o_drive_active && i_fault |-> ##[1:4] !o_drive_active)
    else $error("drive kept after fault");
  wake_start_a: assert property ($rose(o_drive_active) |-> o_seq_start)
    else $error("drive without start pulse");
  start_pulse_a: assert property (o_seq_start |=> !o_seq_start)
    else $error("start pulse too long");
  freq_clamp_a: assert property (($stable(i_freq_hz) && !i_track_en) [*3] |->
    o_drive_freq_hz == (i_freq_hz < 10'h019 ? 10'h019 :
    (i_freq_hz > 10'h3E8 ? 10'h3E8 : i_freq_hz)))
    else $error("drive frequency wrong");
  wave_follow_a: assert property ($stable(i_wave_sel) [*3] |-> o_wave == i_wave_sel)
    else $error("wave shape wrong");
  open_loop_a: assert property (!i_track_en [*3] |-> !o_closed_loop)
    else $error("closed loop while tracking off");
  accel_gate_a: assert property (o_accel_on |-> $past(i_accel_en) &&
    ($past(i_rotating_mass_actuator) || $past(i_track_en)))
    else $error("overdrive not allowed");
  brake_gate_a: assert property (o_brake_on |-> $past(i_brake_en) &&
    ($past(i_rotating_mass_actuator) || $past(i_track_en)))
    else $error("braking not allowed");
  cover property ($rose(o_drive_active));
  cover property (o_drive_active && i_fault);
  cover property (o_accel_on && o_brake_on);
endmodule

// *** tb/hptc_pin_model.sv ***
// trigger pins driven as the far side switches would
`timescale 1ns/1ps
module hptc_pin_model (
  input wire logic i_clk_sys,
  output logic [2:0] o_pins
);
  initial o_pins = 3'h0;
  // one pin changes just after an edge, then holds
  task automatic flip(input int p);
    @(posedge i_clk_sys);
    o_pins[p] <= ~o_pins[p];
  endtask
endmodule

// *** tb/test_hptc_ctrl.sv ***
// self-checking bench for the playback trigger control block
`timescale 1ns/1ps
module test_hptc_ctrl;
  import hptc_pkg::*;
  localparam int WAKE = 20;
  typedef struct {int p; hptc_edge_t e; logic two; logic [3:0] up; logic [3:0] dn;} hptc_row_t;
  hptc_row_t rows [4] = '{'{1, HPTC_EDGE_BOTH, 1'b1, 4'h3, 4'h4},
    '{2, HPTC_EDGE_BOTH, 1'b1, 4'h5, 4'h6}, '{0, HPTC_EDGE_RISE, 1'b0, 4'h1, 4'hF},
    '{0, HPTC_EDGE_FALL, 1'b0, 4'hF, 4'h1}};
  logic i_clk_sys = 0, i_rst_b = 0, i_io_supply_enable_pin = 1, i_host_access = 0;
  logic [2:0] i_trigger_input_pin, i_two_seq = 3'h0;
  hptc_edge_t i_edge_sel [3] = '{HPTC_EDGE_RISE, HPTC_EDGE_RISE, HPTC_EDGE_RISE};
  logic [3:0] i_seq_first [3] = '{4'h1, 4'h3, 4'h5}, i_seq_second [3] = '{4'h2, 4'h4, 4'h6};
  logic i_host_play = 0, i_pwm_in = 0, i_mem_done = 0, i_track_en = 0, i_fault = 0;
  logic i_accel_en = 1, i_brake_en = 1, i_rotating_mass_actuator = 0;
  hptc_src_t i_src_sel = HPTC_SRC_MEM;
  logic [7:0] i_override_level = 8'h00, i_mem_level = 8'hC3;
  logic [9:0] i_freq_hz = 10'h0C8;
  hptc_wave_t i_wave_sel = HPTC_WAVE_SQUARE;
  logic o_drive_active, o_idle, o_seq_start, o_out_p, o_out_n, o_closed_loop;
  logic o_accel_on, o_brake_on;
  logic [3:0] o_seq_id;
  logic [7:0] o_drive_level;
  logic [9:0] o_drive_freq_hz;
  hptc_wave_t o_wave;
  int err_count = 0, tests_run = 0;
  hptc_ctrl #(.WAKE_CYC(WAKE)) u_dut (.*);
  hptc_pin_model u_pins (.i_clk_sys, .o_pins(i_trigger_input_pin));
  always #2.5 i_clk_sys = ~i_clk_sys;
  task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  task automatic wait_start(output logic [3:0] id, output int lat);
    id = 4'hF;
    for (lat = 0; lat < 60 && id === 4'hF; lat++) begin
      @(posedge i_clk_sys);
      #1;
      if (o_seq_start === 1'b1) id = o_seq_id;
    end
  endtask
  task automatic results;
    $display("tests %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [3:0] id;
    int lat, n, same;
    logic prev;
    cyc(5);
    i_rst_b <= 1'b1;
    cyc(2);
    #1 check("reset idle", o_idle, 1'b1);
    foreach (rows[i]) begin
      i_edge_sel[rows[i].p] <= rows[i].e;
      i_two_seq[rows[i].p] <= rows[i].two;
      cyc(2);
      for (int k = 0; k < 2; k++) begin
        u_pins.flip(rows[i].p);
        wait_start(id, lat);
        check("seq id", id, k ? rows[i].dn : rows[i].up);
        if (id !== 4'hF) begin
          check("wake time", lat > WAKE && lat < WAKE + 10, 1'b1);
          cyc(3);
          #1 check("mem level", o_drive_level, i_mem_level);
          @(posedge i_clk_sys) i_mem_done <= 1'b1;
          @(posedge i_clk_sys) i_mem_done <= 1'b0;
          cyc(4);
          #1 check("back to idle", o_idle, 1'b1);
        end
      end
      $display("row %0d done", i);
    end
    u_pins.flip(1);
    wait_start(id, lat);
    i_fault <= 1'b1;
    cyc(5);
    #1 check("fault stop", {o_drive_active, o_idle}, 2'h1);
    u_pins.flip(1);
    wait_start(id, lat);
    check("start under fault", id, 4'hF);
    $display("fault test done");
    i_fault <= 1'b0;
    i_src_sel <= HPTC_SRC_REG;
    i_override_level <= 8'h5A;
    i_rotating_mass_actuator <= 1'b1;
    i_host_play <= 1'b1;
    wait_start(id, lat);
    check("host start", id !== 4'hF, 1'b1);
    cyc(3);
    #1 check("override level", o_drive_level, 8'h5A);
    check("erm assist", {o_accel_on, o_brake_on}, 2'h3);
    n = 0;
    same = 0;
    // first sample only seeds the previous value, so a window holds three rises
    prev = o_out_p;
    repeat (3198) begin
      @(posedge i_clk_sys);
      #1;
      if (o_out_p === 1'b1 && prev === 1'b0) n++;
      if (o_out_p === o_out_n) same++;
      prev = o_out_p;
    end
    check("bridge periods", n, 3);
    check("bridge legs", same, 0);
    i_src_sel <= HPTC_SRC_PWM;
    i_pwm_in <= 1'b1;
    cyc(300);
    #1 check("pwm level", o_drive_level > 8'hE0, 1'b1);
    for (int i = 0; i < 3; i++) begin
      i_freq_hz <= i == 0 ? 10'h00A : (i == 1 ? 10'h1F4 : 10'h3FF);
      i_wave_sel <= hptc_wave_t'(i);
      cyc(4);
      #1 check("freq", o_drive_freq_hz, i == 0 ? 10'h019 : (i == 1 ? 10'h1F4 : 10'h3E8));
      check("wave", o_wave, hptc_wave_t'(i));
    end
    i_track_en <= 1'b1;
    i_rotating_mass_actuator <= 1'b0;
    cyc(4);
    #1 check("closed loop", o_closed_loop, 1'b1);
    check("lra assist", {o_accel_on, o_brake_on}, 2'h3);
    i_track_en <= 1'b0;
    cyc(4);
    #1 check("lra no assist", {o_accel_on, o_brake_on}, 2'h0);
    $display("host test done");
    i_io_supply_enable_pin <= 1'b0;
    cyc(6);
    #1 check("supply off", {o_drive_active, o_idle}, 2'h1);
    check("supply off freq", o_drive_freq_hz, 10'h019);
    i_rst_b <= 1'b0;
    i_host_play <= 1'b0;
    i_io_supply_enable_pin <= 1'b1;
    cyc(5);
    i_rst_b <= 1'b1;
    cyc(4);
    #1 check("reset again idle", {o_drive_active, o_idle}, 2'h1);
    u_pins.flip(1);
    wait_start(id, lat);
    check("odd count cleared", id, 4'h3);
    $display("supply test done");
    results();
  end
  initial begin
    cyc(20000);
    err_count++;
    results();
  end
endmodule
bind hptc_ctrl hptc_ctrl_properties u_props (.*);
